// File: rtl/mst_pkg.sv
// package for the slot timer: constants and carrier types
package mst_pkg;
  localparam int CNT_W = 16;
  localparam int OVF_W = 8;
  localparam int CMD_W = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [CNT_W-1:0] CMP_RESET = 16'hFFFF;
  localparam logic [OVF_W-1:0] OVF_RESET = 8'h00;
  localparam logic [CMD_W-1:0] CMD_RESET = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [OVF_W-1:0] OVF_ONE = 8'h01;
  localparam int FLG_OVF = 0;
  localparam int FLG_CAP = 1;
  localparam int FLG_CMP = 2;
  localparam int FLG_W = 3;

  typedef struct packed {
    logic frame_delim;
    logic tx_end;
  } mst_radio_ev_t;

  typedef struct packed {
    logic strobe;
    logic [CMD_W-1:0] cmd;
  } mst_strobe_t;
endpackage : mst_pkg

// File: rtl/mst_timer.sv
// slot timer core: period counter, overflow tally, capture and compare strobe
`timescale 1ns/1ps
module mst_timer
  import mst_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic RUN,
  input wire logic [CNT_W-1:0] PERIOD,
  input wire logic [CNT_W-1:0] CMP_VALUE,
  input wire logic [CMD_W-1:0] CMP_CMD,
  input wire logic CMP_ENABLE,
  input wire logic CAP_ON_TX_END,
  input wire mst_radio_ev_t RADIO_EV,
  input wire logic [FLG_W-1:0] FLAG_CLEAR,
  output logic [CNT_W-1:0] COUNT,
  output logic [OVF_W-1:0] OVF_COUNT,
  output logic [CNT_W-1:0] CAPTURE,
  output mst_strobe_t RADIO_STROBE,
  output logic [FLG_W-1:0] FLAGS
);
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [OVF_W-1:0] ovf_reg, ovf_next;
  logic [CNT_W-1:0] cap_reg, cap_next;
  mst_strobe_t stb_reg, stb_next;
  logic [FLG_W-1:0] flg_reg, flg_next;
  logic wrap;
  logic cap_ev;
  logic cmp_hit;
  logic [FLG_W-1:0] set_ev;

  always_comb
  begin
    wrap = RUN && (cnt_reg >= PERIOD);
    cap_ev = RADIO_EV.frame_delim || (CAP_ON_TX_END && RADIO_EV.tx_end);
    // match on every cycle that CMP_ENABLE and RUN are high and the counter holds CMP_VALUE, even if it did not just advance into it
    cmp_hit = CMP_ENABLE && RUN && (cnt_reg == CMP_VALUE);
    cnt_next = cnt_reg;
    ovf_next = ovf_reg;
    cap_next = cap_reg;
    stb_next.strobe = 1'b0;
    stb_next.cmd = stb_reg.cmd;
    if (wrap)
    begin
      cnt_next = CNT_RESET;
      ovf_next = ovf_reg + OVF_ONE;
    end
    else if (RUN)
    begin
      cnt_next = cnt_reg + CNT_ONE;
    end
    if (cap_ev)
    begin
      cap_next = cnt_reg;
    end
    if (cmp_hit)
    begin
      stb_next.strobe = 1'b1;
      stb_next.cmd = CMP_CMD;
    end
    set_ev = '0;
    set_ev[FLG_OVF] = wrap;
    set_ev[FLG_CAP] = cap_ev;
    set_ev[FLG_CMP] = cmp_hit;
    // set wins over a clear in the same cycle so no event is lost
    flg_next = (flg_reg & ~FLAG_CLEAR) | set_ev;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cnt_reg <= CNT_RESET;
      ovf_reg <= OVF_RESET;
      cap_reg <= CNT_RESET;
      stb_reg.strobe <= 1'b0;
      stb_reg.cmd <= CMD_RESET;
      flg_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      ovf_reg <= ovf_next;
      cap_reg <= cap_next;
      stb_reg <= stb_next;
      flg_reg <= flg_next;
    end
  end

  assign COUNT = cnt_reg;
  assign OVF_COUNT = ovf_reg;
  assign CAPTURE = cap_reg;
  assign RADIO_STROBE = stb_reg;
  assign FLAGS = flg_reg;
endmodule : mst_timer

// File: bench/mst_timer_assertions.sv
// slot timer port assertions
`timescale 1ns/1ps
module mst_chk import mst_pkg::*;(input CLK,RST,RUN,CMP_ENABLE,CAP_ON_TX_END,
input [15:0] PERIOD,CMP_VALUE,COUNT,CAPTURE,input [7:0] OVF_COUNT,input [2:0] FLAGS,
input mst_radio_ev_t RADIO_EV,input mst_strobe_t RADIO_STROBE);
default clocking @(posedge CLK);endclocking
default disable iff(RST);
AST_WRAP:assert property(RUN&COUNT>=PERIOD|=>COUNT==0&FLAGS[0])else $error("wrap");
AST_OVF:assert property(RUN&COUNT>=PERIOD|=>OVF_COUNT==$past(OVF_COUNT)+8'h01)else $error("ovf");
AST_CAP:assert property(RADIO_EV.frame_delim|=>CAPTURE==$past(COUNT))else $error("cap");
AST_TXE:assert property(RADIO_EV.tx_end&CAP_ON_TX_END|=>CAPTURE==$past(COUNT))else $error("txe");
AST_CMP:assert property(RUN&CMP_ENABLE&COUNT==CMP_VALUE|=>RADIO_STROBE.strobe&FLAGS[2])
else $error("cmp");
AST_FRZ:assert property(!RUN|=>COUNT==$past(COUNT))else $error("frz");
AST_STB:assert property(!(RUN&CMP_ENABLE&COUNT==CMP_VALUE)|=>!RADIO_STROBE.strobe)
else $error("stb");
endmodule:mst_chk
bind mst_timer mst_chk mst_chk_i(.*);

// File: bench/mst_radio.sv
// radio model: sparse random frame events, back to back allowed
`timescale 1ns/1ps
module mst_radio(input CLK,output logic [1:0] EV);
always_ff@(posedge CLK)EV<=$urandom%4?0:$urandom;
endmodule:mst_radio

// File: bench/mst_timer_test.sv
// slot timer bench vs reference model
`timescale 1ns/1ps
module mst_timer_test;
logic CLK=0,RST=1,RUN=0,CMP_ENABLE=0,CAP_ON_TX_END=0;
logic [15:0] PERIOD=0,CMP_VALUE=0,COUNT,CAPTURE;
logic [7:0] OVF_COUNT;
logic [3:0] CMP_CMD=0;
logic [2:0] FLAG_CLEAR=0,FLAGS;
mst_pkg::mst_radio_ev_t RADIO_EV;
mst_pkg::mst_strobe_t RADIO_STROBE;
int c,o,p,s,m,f,num_errors,checked;
always #12.5 CLK=~CLK;
mst_timer mst_timer_i(.*);
mst_radio mst_radio_i(.CLK,.EV(RADIO_EV));
task chk(string n,logic [15:0] g,int e);
checked++;
if(g!==e)begin num_errors++;$display("ERROR %s exp %0d got %0d",n,e,g);end
endtask:chk
always@(posedge CLK)if(RST){c,o,p,s,m,f}=0;else begin
s=0;f&=~FLAG_CLEAR;
if(RADIO_EV[1]|RADIO_EV[0]&CAP_ON_TX_END)begin p=c;f|=2;end
if(RUN&CMP_ENABLE&c==CMP_VALUE)begin s=1;m=CMP_CMD;f|=4;end
if(RUN&c>=PERIOD)begin c=-1;o++;f|=1;end
c+=RUN;end
always@(negedge CLK)if(!RST)begin
chk("cnt",COUNT,c);
chk("ovf",OVF_COUNT,o%256);
chk("cap",CAPTURE,p);
chk("stb",RADIO_STROBE,s*16+m);
chk("flg",FLAGS,f);end
initial begin
void'($urandom(32'hCCCE));
repeat(20)@(posedge CLK);
RST<=0;
repeat(4000)begin
@(posedge CLK);
RUN<=$urandom%6>0;
FLAG_CLEAR<=$urandom%8?0:$urandom;
// small periods so wraps and matches come often
if($urandom%300==0)begin
PERIOD<=$urandom%9;
CMP_VALUE<=$urandom%9;
{CMP_CMD,CMP_ENABLE,CAP_ON_TX_END}<=$urandom;end end
end_sim;end
initial #150us begin num_errors++;end_sim;end
task end_sim;
$display("%0d errors of %0d",num_errors,checked);
if(num_errors==0&&checked>0)$display("NO MISMATCHES");
else $display("MISMATCHES SEEN");
$finish;
endtask:end_sim
endmodule:mst_timer_test
